/* inc/sis_pkg.sv */
// Purpose: shared constants and types of the serial interrupt sampler
// Assumes: 32-bit register bus, 16 serial sources
// Notes: offsets are byte addresses within a 128-byte window
package sis_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int SIS_NSRC = 16;
  localparam int SIS_NPIN = 4;
  localparam int SIS_AW = 7;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [6:0] SIS_OFS_GLOBAL_CFG = 7'h00;
  localparam logic [6:0] SIS_OFS_INT_CFG = 7'h04;
  localparam logic [6:0] SIS_OFS_TASK_PRIO = 7'h08;
  localparam logic [6:0] SIS_OFS_ACK = 7'h0c;
  localparam logic [6:0] SIS_OFS_END_SVC = 7'h10;
  localparam logic [6:0] SIS_OFS_PENDING = 7'h14;
  localparam logic [6:0] SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE = 7'h40;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SIS_GCR_RESET_BIT = 31;
  localparam int SIS_GCR_MIXED_BIT = 29;
  localparam int SIS_ICR_RATIO_LSB = 28;
  localparam int SIS_ICR_SIE_BIT = 27;
  localparam int SIS_VP_MASK_BIT = 31;
  localparam int SIS_VP_ACT_BIT = 30;
  localparam int SIS_VP_POL_BIT = 23;
  localparam int SIS_VP_SENSE_BIT = 22;
  localparam int SIS_VP_PRIO_LSB = 16;
  localparam int SIS_VP_VEC_LSB = 0;

  // ----------------------------------------
  // reset values and codes
  // ----------------------------------------
  localparam logic [2:0] SIS_RATIO_RST = 3'h4;
  localparam logic [2:0] SIS_RATIO_MAX = 3'h6;
  localparam logic [3:0] SIS_TPR_RST = 4'hf;
  localparam logic [7:0] SIS_SPURIOUS_VEC = 8'hff;
  localparam logic [1:0] SIS_GAP_LAST = 2'h3;
  localparam logic [3:0] SIS_SLOT_LAST = 4'hf;
  localparam logic [1:0] SIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SIS_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SIS_SEQ_IDLE = 4'b0001,
    SIS_SEQ_PULSE = 4'b0010,
    SIS_SEQ_GAP = 4'b0100,
    SIS_SEQ_RUN = 4'b1000
  } sis_seq_t;

endpackage

/* rtl/sis_sampler.sv */
// Purpose: serial interrupt front end with pending and selection logic
// Assumes: AXI4-Lite register access, pins synchronous to clock
// Notes: pin0 serial input, pin1 clock, pin2 reset, pin3 frame in serial mode
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sis_sampler (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // axi4-lite write
  input wire logic [sis_pkg::SIS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [sis_pkg::SIS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // shared interrupt pins
  input wire logic [sis_pkg::SIS_NPIN-1:0] irq_pin_i,
  output logic [sis_pkg::SIS_NPIN-1:0] irq_pin_o,
  output logic [sis_pkg::SIS_NPIN-1:0] irq_pin_oe,
  // interrupt toward the core
  output logic irq_out
);
  import sis_pkg::*;

  typedef struct packed {
    logic aw_h;
    logic [SIS_AW-1:0] aw_a;
    logic w_h;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic mixed;
    logic serial_mode_enable;
    logic [2:0] ratio;
    logic [3:0] tpr;
    logic [SIS_NSRC-1:0] mask;
    logic [SIS_NSRC-1:0] pol;
    logic [SIS_NSRC-1:0] sense;
    logic [SIS_NSRC-1:0][3:0] prio;
    logic [SIS_NSRC-1:0][7:0] vec;
    logic [SIS_NSRC-1:0] pend;
    logic [SIS_NSRC-1:0] act;
    sis_seq_t seq;
    logic [1:0] cnt;
    logic [3:0] slot;
    logic fired;
    logic srst;
    logic frame_n;
    logic irq;
  } sis_state_t;

  sis_state_t s_r;
  sis_state_t s_nxt;

  logic serial_on;
  logic sclk;
  logic rise;
  logic [SIS_NSRC-1:0] smp_en;
  logic [SIS_NSRC-1:0] smp_act;
  logic [SIS_NSRC-1:0] pend_upd;
  logic [SIS_NSRC-1:0] ack_clr;
  logic [SIS_NSRC-1:0] cand;
  logic [3:0] sel_id;
  logic sel_ok;
  logic do_wr;
  logic do_rd;
  logic [4:0] wr_idx;
  logic gcr_wr;

  // ----------------------------------------
  // mode and serial clock
  // ----------------------------------------
  assign serial_on = s_r.mixed && s_r.serial_mode_enable;

  sis_sclk_gen u_sclk (
    .clock(clock),
    .resetn(resetn),
    .run(serial_on),
    .ratio(s_r.ratio),
    .sclk(sclk),
    .rise(rise)
  );

  // ----------------------------------------
  // per-source detection
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < SIS_NSRC; gi++) begin : g_src
      // direct mode only sees the four shared pins
      assign smp_en[gi] = serial_on ?
        (rise && s_r.seq == SIS_SEQ_RUN && s_r.slot == 4'(gi)) :
        (s_r.mixed && gi < SIS_NPIN);
      assign smp_act[gi] = (serial_on ? irq_pin_i[0] : irq_pin_i[gi % SIS_NPIN])
        ~^ s_r.pol[gi];
      // set beats acknowledge in the same cycle
      assign pend_upd[gi] = s_r.sense[gi] ?
        (smp_en[gi] ? smp_act[gi] : s_r.pend[gi]) :
        ((smp_en[gi] && smp_act[gi] && !s_r.act[gi]) ||
         (s_r.pend[gi] && !ack_clr[gi]));
      assign cand[gi] = s_r.pend[gi] && !s_r.mask[gi] && s_r.prio[gi] > s_r.tpr;
    end
  endgenerate

  // ----------------------------------------
  // selection of the source to deliver
  // ----------------------------------------
  always_comb begin
    logic [3:0] best;
    best = 4'h0;
    sel_id = 4'h0;
    sel_ok = 1'b0;
    for (int i = 0; i < SIS_NSRC; i++) begin
      if (cand[i] && (!sel_ok || s_r.prio[i] > best)) begin
        sel_ok = 1'b1;
        best = s_r.prio[i];
        sel_id = 4'(i);
      end
    end
  end

  assign do_rd = s_axi_arvalid && !s_r.rvalid;
  assign do_wr = s_r.aw_h && s_r.w_h && !s_r.bvalid;
  assign wr_idx = s_r.aw_a[6:2];
  assign gcr_wr = do_wr && s_r.aw_a == SIS_OFS_GLOBAL_CFG;
  // an acknowledge read takes the edge request into service
  assign ack_clr = (do_rd && s_axi_araddr == SIS_OFS_ACK && sel_ok) ?
    (16'h0001 << sel_id) : 16'h0000;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // ----------------------------------------
  // register read view
  // ----------------------------------------
  function automatic logic [31:0] view(input sis_state_t s, input logic [SIS_AW-1:0] a,
                                       input logic ok, input logic [3:0] id);
    logic [31:0] v;
    logic [3:0] n;
    v = 32'h0;
    n = a[5:2];
    if (a >= SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE) begin
      v[SIS_VP_MASK_BIT] = s.mask[n];
      v[SIS_VP_ACT_BIT] = s.act[n];
      v[SIS_VP_POL_BIT] = s.pol[n];
      v[SIS_VP_SENSE_BIT] = s.sense[n];
      v[SIS_VP_PRIO_LSB +: 4] = s.prio[n];
      v[SIS_VP_VEC_LSB +: 8] = s.vec[n];
    end else begin
      unique case (a)
        SIS_OFS_GLOBAL_CFG: v[SIS_GCR_MIXED_BIT] = s.mixed;
        SIS_OFS_INT_CFG: begin
          v[SIS_ICR_RATIO_LSB +: 3] = s.ratio;
          v[SIS_ICR_SIE_BIT] = s.serial_mode_enable;
        end
        SIS_OFS_TASK_PRIO: v[3:0] = s.tpr;
        SIS_OFS_ACK: v[7:0] = ok ? s.vec[id] : SIS_SPURIOUS_VEC;
        SIS_OFS_PENDING: v[SIS_NSRC-1:0] = s.pend;
        default: v = 32'h0;
      endcase
    end
    return v;
  endfunction

  function automatic logic mapped(input logic [SIS_AW-1:0] a);
    return a[1:0] == 2'h0 && (a >= SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE || a <= SIS_OFS_PENDING);
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] cur;
    logic [31:0] nv;
    logic [3:0] n;
    s_nxt = s_r;
    cur = view(s_r, s_r.aw_a, 1'b0, 4'h0);
    nv = merge(cur, s_r.w_d, s_r.w_s);
    n = wr_idx[3:0];
    s_nxt.pend = pend_upd;
    for (int i = 0; i < SIS_NSRC; i++) begin
      if (smp_en[i]) begin
        s_nxt.act[i] = smp_act[i];
      end
    end
    // bus handshakes
    if (s_axi_awvalid && !s_r.aw_h) begin
      s_nxt.aw_h = 1'b1;
      s_nxt.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_h) begin
      s_nxt.w_h = 1'b1;
      s_nxt.w_d = s_axi_wdata;
      s_nxt.w_s = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (do_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = view(s_r, s_axi_araddr, sel_ok, sel_id);
      s_nxt.rresp = mapped(s_axi_araddr) ? SIS_RESP_OKAY : SIS_RESP_SLVERR;
    end
    if (do_wr) begin
      s_nxt.aw_h = 1'b0;
      s_nxt.w_h = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(s_r.aw_a) ? SIS_RESP_OKAY : SIS_RESP_SLVERR;
      if (s_r.aw_a >= SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE) begin
        s_nxt.mask[n] = nv[SIS_VP_MASK_BIT];
        s_nxt.pol[n] = nv[SIS_VP_POL_BIT];
        s_nxt.sense[n] = nv[SIS_VP_SENSE_BIT];
        s_nxt.prio[n] = nv[SIS_VP_PRIO_LSB +: 4];
        s_nxt.vec[n] = nv[SIS_VP_VEC_LSB +: 8];
      end else if (s_r.aw_a == SIS_OFS_GLOBAL_CFG) begin
        s_nxt.mixed = nv[SIS_GCR_MIXED_BIT];
      end else if (s_r.aw_a == SIS_OFS_INT_CFG) begin
        s_nxt.ratio = nv[SIS_ICR_RATIO_LSB +: 3];
        s_nxt.serial_mode_enable = nv[SIS_ICR_SIE_BIT];
      end else if (s_r.aw_a == SIS_OFS_TASK_PRIO) begin
        s_nxt.tpr = nv[3:0];
      end
    end
    // serial sequence
    unique case (s_r.seq)
      SIS_SEQ_IDLE: begin
        if (serial_on) begin
          // a second enable without reset skips the pulse
          s_nxt.seq = s_r.fired ? SIS_SEQ_GAP : SIS_SEQ_PULSE;
          s_nxt.cnt = 2'h0;
        end
      end
      SIS_SEQ_PULSE: begin
        s_nxt.srst = 1'b1;
        s_nxt.fired = 1'b1;
        if (rise && s_r.srst) begin
          s_nxt.cnt = s_r.cnt + 2'h1;
          if (s_r.cnt == 2'h1) begin
            s_nxt.srst = 1'b0;
            s_nxt.seq = SIS_SEQ_GAP;
            s_nxt.cnt = 2'h0;
          end
        end
      end
      SIS_SEQ_GAP: begin
        if (rise) begin
          s_nxt.cnt = s_r.cnt + 2'h1;
          if (s_r.cnt == SIS_GAP_LAST) begin
            s_nxt.seq = SIS_SEQ_RUN;
            s_nxt.slot = 4'h0;
          end
        end
      end
      SIS_SEQ_RUN: begin
        if (rise) begin
          s_nxt.slot = s_r.slot + 4'h1;
        end
      end
    endcase
    if (!serial_on) begin
      s_nxt.seq = SIS_SEQ_IDLE;
      s_nxt.srst = 1'b0;
      s_nxt.slot = 4'h0;
    end
    s_nxt.frame_n = !(s_nxt.seq == SIS_SEQ_RUN && s_nxt.slot == 4'h0);
    // pass-through forwards pin zero untouched
    s_nxt.irq = s_r.mixed ? sel_ok : irq_pin_i[0];
    // controller reset bit acts at once and reads back as zero
    if (do_wr && s_r.aw_a == SIS_OFS_GLOBAL_CFG && nv[SIS_GCR_RESET_BIT]) begin
      s_nxt.mixed = 1'b0;
      s_nxt.serial_mode_enable = 1'b0;
      s_nxt.ratio = SIS_RATIO_RST;
      s_nxt.tpr = SIS_TPR_RST;
      s_nxt.mask = '1;
      s_nxt.pend = '0;
      s_nxt.fired = 1'b0;
      s_nxt.seq = SIS_SEQ_IDLE;
      s_nxt.srst = 1'b0;
      s_nxt.frame_n = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.ratio <= SIS_RATIO_RST;
      s_r.tpr <= SIS_TPR_RST;
      s_r.mask <= '1;
      s_r.seq <= SIS_SEQ_IDLE;
      s_r.frame_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = !s_r.aw_h;
  assign s_axi_wready = !s_r.w_h;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign irq_pin_o = {s_r.frame_n, s_r.srst, sclk, 1'b0};
  assign irq_pin_oe = serial_on ? 4'he : 4'h0;
  assign irq_out = s_r.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence pulse_end_s;
    $fell(s_r.srst) && s_r.seq == SIS_SEQ_GAP;
  endsequence
  sequence gap_done_s;
    s_r.seq == SIS_SEQ_GAP && rise && s_r.cnt == SIS_GAP_LAST && serial_on && !gcr_wr;
  endsequence

  mode_gate_a: assert property (!serial_on |=> s_r.seq == SIS_SEQ_IDLE && !s_r.srst)
    else $error("serial sequence active outside serial mode");
  pin_share_a: assert property (serial_on |-> irq_pin_oe == 4'he && !irq_pin_oe[0])
    else $error("shared pins not turned in serial mode");
  pulse_len_a: assert property (pulse_end_s |->
    $past(rise) && $past(s_r.cnt) == 2'h1) else $error("serial reset pulse length wrong");
  gap_len_a: assert property (pulse_end_s |-> s_r.cnt == 2'h0 && !rise)
    else $error("gap after serial reset misaligned");
  first_slot_a: assert property (gap_done_s |=> s_r.seq == SIS_SEQ_RUN &&
    s_r.slot == 4'h0 && !s_r.frame_n) else $error("first slot not at fifth rise");
  slot_wrap_a: assert property (s_r.seq == SIS_SEQ_RUN && serial_on && rise &&
    s_r.slot == SIS_SLOT_LAST && !gcr_wr |=> s_r.slot == 4'h0 && !s_r.frame_n)
    else $error("slot counter did not wrap to zero");
  frame_mark_a: assert property (!s_r.frame_n |-> s_r.seq == SIS_SEQ_RUN &&
    s_r.slot == 4'h0) else $error("frame active off slot zero");
  reset_once_a: assert property ($rose(s_r.srst) |-> !$past(s_r.fired))
    else $error("serial reset pulse repeated");
  level_clear_a: assert property (smp_en[0] && s_r.sense[0] && !smp_act[0] &&
    !(do_wr && s_r.aw_a == SIS_OFS_GLOBAL_CFG) |=> !s_r.pend[0])
    else $error("level pending kept after inactive sample");
  edge_ack_a: assert property (ack_clr != 16'h0 && !s_r.sense[sel_id] &&
    !smp_en[sel_id] |=> !s_r.pend[$past(sel_id)])
    else $error("edge pending kept after acknowledge");
  eos_zero_a: assert property (do_rd && s_axi_araddr == SIS_OFS_END_SVC |=>
    s_axi_rvalid && s_axi_rdata == 32'h0) else $error("end-of-service read not zero");
  ctl_reset_a: assert property (do_wr && s_r.aw_a == SIS_OFS_GLOBAL_CFG &&
    s_r.w_s[3] && s_r.w_d[SIS_GCR_RESET_BIT] |=> s_r.ratio == SIS_RATIO_RST &&
    !s_r.mixed && s_r.mask == 16'hffff && s_r.pend == 16'h0000)
    else $error("controller reset left state behind");

endmodule
`default_nettype wire

/* rtl/sis_sclk_gen.sv */
// Purpose: serial clock divider for the sampler
// Assumes: ratio field 0..6 gives divide by 2..14
// Notes: rise is a one-cycle pulse in the cycle sclk goes high
`timescale 1ns/1ps
`default_nettype none
module sis_sclk_gen (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic [2:0] ratio,
  // serial clock
  output logic sclk,
  output logic rise
);
  import sis_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic sclk;
    logic rise;
  } sis_div_t;

  sis_div_t s_r;
  sis_div_t s_nxt;
  logic [2:0] half_last;

  // --------------------------------
  // divider
  // --------------------------------
  // illegal code 7 clamps to the slowest legal ratio
  assign half_last = (ratio > SIS_RATIO_MAX) ? SIS_RATIO_MAX : ratio;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rise = 1'b0;
    if (!run) begin
      s_nxt.cnt = 3'h0;
      s_nxt.sclk = 1'b0;
    end else if (s_r.cnt >= half_last) begin
      s_nxt.cnt = 3'h0;
      s_nxt.sclk = !s_r.sclk;
      s_nxt.rise = !s_r.sclk;
    end else begin
      s_nxt.cnt = s_r.cnt + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sclk = s_r.sclk;
  assign rise = s_r.rise;

  // --------------------------------
  // checks
  // --------------------------------
  half_period_a: assert property (@(posedge clock) disable iff (!resetn)
    (run && $rose(s_r.sclk) && ratio == 3'h0) |=> !s_r.sclk)
    else $error("serial clock half period wrong at ratio 0");

endmodule
`default_nettype wire

/* test/sis_source_model.sv */
// Purpose: behavioural model of the serial interrupt source device
// Assumes: frame is active low and marks the period before slot 0 is sampled
// Notes: drives one source level per serial clock period on the serial input
`timescale 1ns/1ps
`default_nettype none
module sis_source_model (
  // serial link from the sampler
  input wire logic sclk,
  input wire logic srst,
  input wire logic frame_n,
  // raw source levels
  input wire logic [15:0] lines,
  // serial input toward the sampler
  output logic sdata
);
  logic [3:0] slot;
  logic synced;

  initial begin
    slot = 4'h0;
    sdata = 1'b0;
    synced = 1'b0;
  end

  // ----------------------------------------
  // slot tracking
  // ----------------------------------------
  // until the first frame the line is not owned: toggle so no value is trusted
  always @(posedge srst) begin
    synced = 1'b0;
  end

  always @(negedge sclk) begin
    // at ratio 0 frame and clock move on one edge: let both settle first
    #1;
    if (!frame_n) begin
      synced = 1'b1;
    end
    slot = frame_n ? slot + 4'h1 : 4'h0;
    sdata = synced ? lines[slot] : ~sdata;
  end
endmodule
`default_nettype wire

/* test/tb_serial_interrupt_sampler.sv */
// Purpose: self-checking bench of the serial interrupt sampler
// Assumes: 250 MHz clock, write strobes full unless a test narrows them
// Notes: pin monitor counts serial rises from settled clock samples
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb_serial_interrupt_sampler;
  import sis_pkg::*;
  logic clock, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq_out, sdata;
  logic psclk, psrst, synced;
  logic [6:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat, lfsr;
  logic [1:0] bresp, rresp, lresp;
  logic [3:0] pin_i, pin_o, pin_oe, direct, wstrb;
  logic [15:0] lines;
  int mismatches, num_checks, hi_rises, gap_rises, since, pulses;
  int pr[16];

  // ----------------------------------------
  // clock, pins, instances
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // the wire level: driven outputs win, else far side or bench
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & {direct[3:1], pin_oe[1] ? sdata : direct[0]});

  sis_sampler dut (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_pin_i(pin_i), .irq_pin_o(pin_o),
    .irq_pin_oe(pin_oe), .irq_out(irq_out));
  sis_source_model far (.sclk(pin_o[1]), .srst(pin_o[2]), .frame_n(pin_o[3]),
    .lines(lines), .sdata(sdata));

  // ----------------------------------------
  // pin monitor
  // ----------------------------------------
  always @(posedge pin_o[2]) pulses++;
  always @(posedge clock) begin
    psclk <= pin_o[1];
    psrst <= pin_o[2];
    if (pin_o[1] && !psclk) begin
      since <= since + 1;
      // a rise before the pulse is no gap rise; the frame rise samples slot 0
      if (psrst) begin
        hi_rises <= hi_rises + 1;
        gap_rises <= 0;
      end else if (!synced && pin_o[3]) begin
        gap_rises <= gap_rises + 1;
      end
      if (!pin_o[3]) begin
        if (synced) `CHK(since, 16)
        synced <= 1'b1;
        since <= 1;
      end
    end
  end

  // ----------------------------------------
  // bus tasks and reference model
  // ----------------------------------------
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clock); while (!bvalid);
    lresp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (!rvalid);
    rdat = rdata;
    lresp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a);
    `CHK(rdat & m, e)
  endtask

  task automatic rises(input int n);
    repeat (n) @(posedge pin_o[1]);
    @(posedge clock);
  endtask

  // skips one period so a ratio change never lands inside the measurement
  task automatic per(input int r);
    longint t0;
    rises(1);
    @(posedge pin_o[1]);
    t0 = $time;
    @(posedge pin_o[1]);
    `CHK(int'(($time - t0) / 4), 2 * (r + 1))
    @(posedge clock);
  endtask

  task automatic arm;
    hi_rises = 0;
    gap_rises = 0;
    synced = 1'b0;
  endtask

  function automatic logic [31:0] vp(input logic m, pol, sen, input int n);
    return {m, 7'h0, pol, sen, 2'h0, 4'(pr[n]), 8'h0, 8'(n + 32)};
  endfunction

  // highest priority wins, lower index on a tie
  function automatic logic [7:0] best(input logic [15:0] p);
    int b;
    b = -1;
    for (int n = 0; n < 16; n++) if (p[n] && (b < 0 || pr[n] > pr[b])) b = n;
    return b < 0 ? SIS_SPURIOUS_VEC : 8'(b + 32);
  endfunction

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end

  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, direct, lines} = '0;
    wstrb = 4'hf;
    lfsr = 32'h44c9b80e;
    {mismatches, num_checks, since, pulses} = '0;
    arm();
    for (int n = 0; n < 16; n++) pr[n] = (n * 5) % 15 + 1;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rc(SIS_OFS_GLOBAL_CFG, 32'h0, '1);
    rc(SIS_OFS_INT_CFG, {1'b0, SIS_RATIO_RST, 28'h0}, '1);
    rc(SIS_OFS_TASK_PRIO, 32'hf, '1);
    for (int n = 0; n < 16; n++) rc(SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE + 7'(4 * n), 32'h80000000, 32'hbfffffff);
    rc(7'h18, 32'h0, '1);
    `CHK(lresp, SIS_RESP_SLVERR)
    direct <= 4'h1;
    repeat (3) @(posedge clock);
    `CHK(irq_out, 1'b1)
    tend("reset and pass-through");
    wr(SIS_OFS_GLOBAL_CFG, 32'h7fffffff);
    rc(SIS_OFS_GLOBAL_CFG, 32'h20000000, '1);
    direct <= 4'h0;
    for (int n = 0; n < 16; n++) wr(SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE + 7'(4 * n), vp(1, 1, 1, n));
    wr(SIS_OFS_TASK_PRIO, 32'h0);
    arm();
    wr(SIS_OFS_INT_CFG, 32'h08000000);
    `CHK(pin_oe, 4'he)
    for (int n = 0; n < 16; n++) wr(SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE + 7'(4 * n), vp(0, 1, 1, n));
    rises(40);
    `CHK(hi_rises, 2)
    `CHK(gap_rises, 4)
    repeat (5) begin
      lfsr = nxt(lfsr);
      lines <= lfsr[15:0];
      rises(34);
      rc(SIS_OFS_PENDING, {16'h0, lines}, '1);
      rc(SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE + 7'h0c, {1'b0, lines[3], 30'h0}, 32'h40000000);
      `CHK(irq_out, |lines)
      rd(SIS_OFS_ACK);
      `CHK(rdat[7:0], best(lines))
    end
    tend("level sources");
    lines <= 16'h0020;
    wr(SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE + 7'h14, vp(1, 1, 0, 5));
    rises(34);
    lines <= 16'h0;
    rises(34);
    rc(SIS_OFS_PENDING, 32'h20, '1);
    wr(SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE + 7'h14, vp(1, 1, 1, 5));
    rises(34);
    rc(SIS_OFS_PENDING, 32'h0, '1);
    wr(SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE + 7'h14, vp(0, 1, 0, 5));
    rises(34);
    lines <= 16'h0020;
    rises(34);
    rc(SIS_OFS_PENDING, 32'h20, '1);
    rd(SIS_OFS_ACK);
    `CHK(rdat[7:0], 8'h25)
    rises(34);
    rc(SIS_OFS_PENDING, 32'h0, '1);
    tend("edge source");
    for (int r = 0; r < 7; r++) begin
      wr(SIS_OFS_INT_CFG, {1'b0, 3'(r), 1'b1, 27'h0});
      per(r);
    end
    tend("ratios");
    wr(SIS_OFS_INT_CFG, 32'h0);
    `CHK(pin_oe, 4'h0)
    arm();
    wr(SIS_OFS_INT_CFG, 32'h08000000);
    rises(40);
    `CHK(pulses, 1)
    `CHK(gap_rises, 4)
    wr(SIS_OFS_GLOBAL_CFG, 32'h80000000);
    rc(SIS_OFS_GLOBAL_CFG, 32'h0, '1);
    rc(SIS_OFS_INT_CFG, {1'b0, SIS_RATIO_RST, 28'h0}, '1);
    rc(SIS_OFS_SERIAL_VECTOR_PRIORITY_REG_BASE, vp(1, 1, 1, 0), 32'hbfffffff);
    rc(SIS_OFS_PENDING, 32'h0, '1);
    wr(SIS_OFS_GLOBAL_CFG, 32'h20000000);
    arm();
    wr(SIS_OFS_INT_CFG, 32'h08000000);
    rises(40);
    `CHK(pulses, 2)
    `CHK(hi_rises, 2)
    wr(SIS_OFS_END_SVC, 32'hffffffff);
    `CHK(lresp, SIS_RESP_OKAY)
    wr(7'h1c, 32'h1);
    `CHK(lresp, SIS_RESP_SLVERR)
    wstrb <= 4'he;
    wr(SIS_OFS_TASK_PRIO, 32'h5);
    wstrb <= 4'hf;
    rc(SIS_OFS_TASK_PRIO, 32'hf, '1);
    rc(SIS_OFS_END_SVC, 32'h0, '1);
    tend("reset pulse and readback");
    report_and_stop;
  end
endmodule
`default_nettype wire
